// ---- src/vmc_pkg.sv ----
// constants shared by the regulator voltage monitor control block
// assumes a single 200 MHz clock and a classic wishbone register bus
package vmc_pkg;

  // ------------------------------------------------------------
  // structure
  // ------------------------------------------------------------
  localparam int unsigned NUM_BUCK = 5;
  localparam int unsigned NUM_LIN  = 3;
  localparam int unsigned NCH      = NUM_BUCK + NUM_LIN;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned PCT_W    = 7;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ    = 200;
  localparam int unsigned UV_DB0_NS  = 5000;
  localparam int unsigned UV_DB1_NS  = 15000;
  localparam int unsigned UV_DB2_NS  = 25000;
  localparam int unsigned UV_DB3_NS  = 40000;
  localparam int unsigned OV_DB0_NS  = 25000;
  localparam int unsigned OV_DB1_NS  = 50000;
  localparam int unsigned OV_DB2_NS  = 80000;
  localparam int unsigned OV_DB3_NS  = 125000;
  localparam int unsigned SETTLE_NS  = 30000;
  // least times round up to whole cycles
  localparam int unsigned UV_DB0_CYC = (UV_DB0_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned UV_DB1_CYC = (UV_DB1_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned UV_DB2_CYC = (UV_DB2_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned UV_DB3_CYC = (UV_DB3_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OV_DB0_CYC = (OV_DB0_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OV_DB1_CYC = (OV_DB1_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OV_DB2_CYC = (OV_DB2_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OV_DB3_CYC = (OV_DB3_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  // ------------------------------------------------------------
  // trip point tables, percent of nominal, indexed by code
  // ------------------------------------------------------------
  localparam logic [3:0][PCT_W-1:0] LOW_PCT_TAB  = {7'h59, 7'h5b, 7'h5d, 7'h5f};
  localparam logic [3:0][PCT_W-1:0] HIGH_PCT_TAB = {7'h6f, 7'h6d, 7'h6b, 7'h69};

  // ------------------------------------------------------------
  // register map (byte offsets) and fields
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_MON_EN    = 8'h04;
  localparam logic [7:0] OFS_KEY       = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;
  localparam int unsigned CTRL_LOW_SEL_LSB  = 0;
  localparam int unsigned CTRL_HIGH_SEL_LSB = 2;
  localparam int unsigned CTRL_SECURE_BIT   = 4;
  localparam logic [1:0] LOW_SEL_RST  = 2'h2;
  localparam logic [1:0] HIGH_SEL_RST = 2'h0;
  localparam logic       SECURE_RST   = 1'h0;
  localparam logic [7:0] MON_EN_RST   = 8'hff;
  localparam logic [15:0] IRQ_MASK_RST = 16'h0000;
  localparam logic [7:0] UNLOCK_KEY   = 8'ha5;

endpackage : vmc_pkg

// ---- src/vmc_top.sv ----
// digital control of per-regulator under/overvoltage supervision
// assumes comparator, regulator-on and in-regulation inputs are asynchronous
// and that software reaches the registers over classic wishbone
// Functional notes
// RULE1: low trip point from two-bit code: 95, 93, 91, 89 percent
// RULE2: high trip point from two-bit code: 105, 107, 109, 111 percent
// RULE3: shared low debounce: 5, 15, 25, 40 us by two-bit select
// RULE4: low debounce select resets to binary 10
// RULE5: shared high debounce: 25, 50, 80, 125 us by two-bit select
// RULE6: high debounce select resets to binary 00
// RULE7: one monitor enable bit per regulator; 1 supervises, 0 does not
// RULE8: all monitor enable bits start at 1 after power up
// RULE9: in secure mode, enable bits change only through the unlock sequence
// RULE10: monitor masked after regulator turn-on until it reaches regulation
// RULE11: disabled monitor forces its low and high status to 0
// RULE12: comparator ignored for 30 us after a monitor is enabled
// RULE13: status set only after full debounce; timer restarts on dropout
// RULE14: status set raises an event; status follows debounced condition
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module vmc_top
  import vmc_pkg::*;
#(
  parameter int unsigned UV0_CYC    = UV_DB0_CYC,
  parameter int unsigned UV1_CYC    = UV_DB1_CYC,
  parameter int unsigned UV2_CYC    = UV_DB2_CYC,
  parameter int unsigned UV3_CYC    = UV_DB3_CYC,
  parameter int unsigned OV0_CYC    = OV_DB0_CYC,
  parameter int unsigned OV1_CYC    = OV_DB1_CYC,
  parameter int unsigned OV2_CYC    = OV_DB2_CYC,
  parameter int unsigned OV3_CYC    = OV_DB3_CYC,
  parameter int unsigned SETTLE_LIM = SETTLE_CYC
) (
  input  wire  logic                             clk_i,
  input  wire  logic                             rstn_i,
  input  wire  logic                             wb_cyc_i,
  input  wire  logic                             wb_stb_i,
  input  wire  logic                             wb_we_i,
  input  wire  logic [7:0]                       wb_adr_i,
  input  wire  logic [3:0]                       wb_sel_i,
  input  wire  logic [31:0]                      wb_dat_i,
  output logic       [31:0]                      wb_dat_o,
  output logic                                   wb_ack_o,
  input  wire  logic [NUM_BUCK-1:0][1:0]         buck_low_trip_code_i,
  input  wire  logic [NUM_LIN-1:0][1:0]          linear_low_trip_code_i,
  input  wire  logic [NUM_BUCK-1:0][1:0]         buck_high_trip_code_i,
  input  wire  logic [NUM_LIN-1:0][1:0]          linear_high_trip_code_i,
  input  wire  logic [NCH-1:0]                   reg_on_i,
  input  wire  logic [NCH-1:0]                   reg_in_regulation_i,
  input  wire  logic [NCH-1:0]                   low_cmp_i,
  input  wire  logic [NCH-1:0]                   high_cmp_i,
  output logic       [NCH-1:0][PCT_W-1:0]        low_trip_pct_o,
  output logic       [NCH-1:0][PCT_W-1:0]        high_trip_pct_o,
  output logic       [NCH-1:0]                   monitor_active_o,
  output logic       [NCH-1:0]                   low_fault_status_o,
  output logic       [NCH-1:0]                   high_fault_status_o,
  output logic                                   irq_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [CNT_W-1:0] pick_lim(input logic [1:0] s, input int unsigned a,
                                                input int unsigned b, input int unsigned c,
                                                input int unsigned d);
    case (s)
      2'h0:    pick_lim = CNT_W'(a);
      2'h1:    pick_lim = CNT_W'(b);
      2'h2:    pick_lim = CNT_W'(c);
      default: pick_lim = CNT_W'(d);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v,
                                               input logic [CNT_W-1:0] lim);
    sat_inc = (v >= lim) ? lim : v + 16'h0001;
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [NCH-1:0]        on_s1, on_s2, pg_s1, pg_s2, lc_s1, lc_s2, hc_s1, hc_s2;
  logic [NCH-1:0][1:0]   lcode_s1, lcode_s2, hcode_s1, hcode_s2;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      on_s1 <= '0; on_s2 <= '0; pg_s1 <= '0; pg_s2 <= '0;
      lc_s1 <= '0; lc_s2 <= '0; hc_s1 <= '0; hc_s2 <= '0;
      lcode_s1 <= '0; lcode_s2 <= '0; hcode_s1 <= '0; hcode_s2 <= '0;
    end
    else
    begin
      on_s1 <= reg_on_i;            on_s2 <= on_s1;
      pg_s1 <= reg_in_regulation_i; pg_s2 <= pg_s1;
      lc_s1 <= low_cmp_i;           lc_s2 <= lc_s1;
      hc_s1 <= high_cmp_i;          hc_s2 <= hc_s1;
      lcode_s1 <= {linear_low_trip_code_i, buck_low_trip_code_i};
      lcode_s2 <= lcode_s1;
      hcode_s1 <= {linear_high_trip_code_i, buck_high_trip_code_i};
      hcode_s2 <= hcode_s1;
    end
  end

  // ------------------------------------------------------------
  // register file and wishbone slave
  // ------------------------------------------------------------
  logic        ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic [1:0]  low_sel_reg, low_sel_next, high_sel_reg, high_sel_next;
  logic        secure_reg, secure_next, armed_reg, armed_next;
  logic [NCH-1:0] mon_en_reg, mon_en_next;
  logic [15:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  logic [NCH-1:0] low_stat_reg, low_stat_next, high_stat_reg, high_stat_next;
  logic        acc, do_wr, b0, b1, wr_monen;
  logic [15:0] events;

  assign acc    = wb_cyc_i & wb_stb_i;
  assign do_wr  = acc & ack_reg & wb_we_i;
  assign b0     = wb_sel_i[0];
  assign b1     = wb_sel_i[1];
  assign wr_monen = do_wr & b0 & (wb_adr_i == OFS_MON_EN);
  // hardware events win over a write-one-to-clear in the same cycle
  assign events = {high_stat_next & ~high_stat_reg, low_stat_next & ~low_stat_reg}; // RULE14

  always_comb
  begin
    ack_next      = acc & ~ack_reg;
    dat_next      = dat_reg;
    low_sel_next  = low_sel_reg;
    high_sel_next = high_sel_reg;
    secure_next   = secure_reg;
    armed_next    = armed_reg;
    mon_en_next   = mon_en_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (acc & ~ack_reg)
    begin
      case (wb_adr_i)
        OFS_CTRL:     dat_next = {27'h0, secure_reg, high_sel_reg, low_sel_reg};
        OFS_MON_EN:   dat_next = {24'h0, mon_en_reg};
        OFS_STATUS:   dat_next = {16'h0, high_stat_reg, low_stat_reg};
        OFS_IRQ_STAT: dat_next = {16'h0, irq_stat_reg};
        OFS_IRQ_MASK: dat_next = {16'h0, irq_mask_reg};
        default:      dat_next = 32'h0;
      endcase
    end
    if (do_wr)
    begin
      // any write other than the unlock key itself spends the unlock
      armed_next = 1'b0;
      case (wb_adr_i)
        OFS_CTRL:
          if (b0)
          begin
            low_sel_next  = wb_dat_i[CTRL_LOW_SEL_LSB +: 2];
            high_sel_next = wb_dat_i[CTRL_HIGH_SEL_LSB +: 2];
            secure_next   = wb_dat_i[CTRL_SECURE_BIT];
          end
        OFS_MON_EN:
          if (b0 & (~secure_reg | armed_reg)) // RULE9
            mon_en_next = wb_dat_i[NCH-1:0]; // RULE7
        OFS_KEY:
          if (b0)
            armed_next = (wb_dat_i[7:0] == UNLOCK_KEY); // RULE9
        OFS_IRQ_STAT:
        begin
          if (b0)
            irq_stat_next[7:0]  = irq_stat_reg[7:0] & ~wb_dat_i[7:0];
          if (b1)
            irq_stat_next[15:8] = irq_stat_reg[15:8] & ~wb_dat_i[15:8];
        end
        OFS_IRQ_MASK:
        begin
          if (b0)
            irq_mask_next[7:0]  = wb_dat_i[7:0];
          if (b1)
            irq_mask_next[15:8] = wb_dat_i[15:8];
        end
        default: ;
      endcase
    end
    irq_stat_next = irq_stat_next | events; // RULE14
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack_reg      <= 1'b0;
      dat_reg      <= 32'h0;
      low_sel_reg  <= LOW_SEL_RST;  // RULE4
      high_sel_reg <= HIGH_SEL_RST; // RULE6
      secure_reg   <= SECURE_RST;
      armed_reg    <= 1'b0;
      mon_en_reg   <= MON_EN_RST;   // RULE8
      irq_stat_reg <= 16'h0;
      irq_mask_reg <= IRQ_MASK_RST;
    end
    else
    begin
      ack_reg      <= ack_next;
      dat_reg      <= dat_next;
      low_sel_reg  <= low_sel_next;
      high_sel_reg <= high_sel_next;
      secure_reg   <= secure_next;
      armed_reg    <= armed_next;
      mon_en_reg   <= mon_en_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o    = |(irq_stat_reg & irq_mask_reg);

  // ------------------------------------------------------------
  // per-regulator monitors
  // ------------------------------------------------------------
  logic [CNT_W-1:0] low_lim, high_lim, settle_lim;
  logic [NCH-1:0][CNT_W-1:0] uv_cnt_reg, uv_cnt_next, ov_cnt_reg, ov_cnt_next;
  logic [NCH-1:0][CNT_W-1:0] settle_reg, settle_next;
  logic [NCH-1:0] reached_reg, reached_next, en_d_reg, active_reg, active_next;
  logic [NCH-1:0][PCT_W-1:0] low_pct_reg, low_pct_next, high_pct_reg, high_pct_next;

  assign low_lim    = pick_lim(low_sel_reg, UV0_CYC, UV1_CYC, UV2_CYC, UV3_CYC); // RULE3
  assign high_lim   = pick_lim(high_sel_reg, OV0_CYC, OV1_CYC, OV2_CYC, OV3_CYC); // RULE5
  assign settle_lim = CNT_W'(SETTLE_LIM);

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      low_pct_next[i]  = LOW_PCT_TAB[lcode_s2[i]];  // RULE1
      high_pct_next[i] = HIGH_PCT_TAB[hcode_s2[i]]; // RULE2
      // masked from turn-on until the regulator reports regulation
      reached_next[i]  = on_s2[i] & (reached_reg[i] | pg_s2[i]); // RULE10
      // settling restarts on every enable, including the one at reset
      if (!mon_en_reg[i] || !en_d_reg[i])
        settle_next[i] = '0; // RULE12
      else
        settle_next[i] = sat_inc(settle_reg[i], settle_lim);
      active_next[i]   = mon_en_reg[i] & reached_reg[i] & (settle_reg[i] >= settle_lim); // RULE11
      uv_cnt_next[i]   = (active_next[i] & lc_s2[i]) ? sat_inc(uv_cnt_reg[i], low_lim) : '0; // RULE13
      ov_cnt_next[i]   = (active_next[i] & hc_s2[i]) ? sat_inc(ov_cnt_reg[i], high_lim) : '0; // RULE13
      low_stat_next[i]  = active_next[i] & (uv_cnt_next[i] >= low_lim);  // RULE13
      high_stat_next[i] = active_next[i] & (ov_cnt_next[i] >= high_lim); // RULE13
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      low_pct_reg   <= '0;
      high_pct_reg  <= '0;
      reached_reg   <= '0;
      en_d_reg      <= '0;
      settle_reg    <= '0;
      active_reg    <= '0;
      uv_cnt_reg    <= '0;
      ov_cnt_reg    <= '0;
      low_stat_reg  <= '0;
      high_stat_reg <= '0;
    end
    else
    begin
      low_pct_reg   <= low_pct_next;
      high_pct_reg  <= high_pct_next;
      reached_reg   <= reached_next;
      en_d_reg      <= mon_en_reg;
      settle_reg    <= settle_next;
      active_reg    <= active_next;
      uv_cnt_reg    <= uv_cnt_next;
      ov_cnt_reg    <= ov_cnt_next;
      low_stat_reg  <= low_stat_next;
      high_stat_reg <= high_stat_next;
    end
  end

  assign low_trip_pct_o      = low_pct_reg;
  assign high_trip_pct_o     = high_pct_reg;
  assign monitor_active_o    = active_reg;
  assign low_fault_status_o  = low_stat_reg;
  assign high_fault_status_o = high_stat_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic [CNT_W-1:0] hlp_uv, hlp_ov;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hlp_uv <= '0;
      hlp_ov <= '0;
    end
    else
    begin
      hlp_uv <= (active_next[0] & lc_s2[0]) ? hlp_uv + 16'h0001 : '0;
      hlp_ov <= (active_next[0] & hc_s2[0]) ? hlp_ov + 16'h0001 : '0;
    end
  end

  chk_low_trip_map: assert property (lcode_s2[0] == 2'h3 |=> low_trip_pct_o[0] == 7'h59) // RULE1
    else $error("low trip code 11 did not give 89 percent");
  chk_high_trip_map: assert property (hcode_s2[0] == 2'h0 |=> high_trip_pct_o[0] == 7'h69) // RULE2
    else $error("high trip code 00 did not give 105 percent");
  chk_low_debounce_len: assert property ($rose(low_fault_status_o[0]) |-> hlp_uv >= low_lim) // RULE3
    else $error("low status rose before debounce interval");
  chk_high_debounce_len: assert property ($rose(high_fault_status_o[0]) |-> hlp_ov >= high_lim) // RULE5
    else $error("high status rose before debounce interval");
  chk_reset_defaults: assert property (disable iff (1'b0) // RULE4
    (rstn_i && !$past(rstn_i)) |-> (low_sel_reg == 2'h2 && high_sel_reg == 2'h0 // RULE6
                                    && mon_en_reg == 8'hff)) // RULE8
    else $error("control fields not at reset defaults");
  chk_secure_enable_lock: assert property ((wr_monen && secure_reg && !armed_reg) // RULE9
    |=> $stable(mon_en_reg))
    else $error("enable bits changed without unlock in secure mode");
  chk_mask_until_reg: assert property (!reached_reg[0] |=> !low_fault_status_o[0] // RULE10
    && !high_fault_status_o[0])
    else $error("status set before regulation was reached");
  chk_disable_clears: assert property (mon_en_reg != 8'hff |=> ((low_fault_status_o // RULE11
    | high_fault_status_o | monitor_active_o) & ~$past(mon_en_reg)) == 8'h00) // RULE7
    else $error("disabled monitor shows status");
  chk_settle_blank: assert property ($rose(mon_en_reg[3]) |=> !monitor_active_o[3] [*8]) // RULE12
    else $error("monitor active during settling");
  chk_event_flag: assert property ($rose(low_fault_status_o[0]) |-> irq_stat_reg[0]) // RULE14
    else $error("low status rise did not set event");
  chk_status_follows: assert property (low_fault_status_o[0] && !lc_s2[0] // RULE14
    |=> !low_fault_status_o[0])
    else $error("low status held after condition cleared");

  cov_low_fault: cover property ($rose(low_fault_status_o[0]));
  cov_high_fault: cover property ($rose(high_fault_status_o[0]));
  cov_secure_write: cover property (wr_monen && secure_reg && armed_reg);
  cov_irq: cover property ($rose(irq_o));

endmodule // vmc_top

// ---- testbench/vmc_analog_model.sv ----
// behavioural regulators and comparators at the far side of the monitor block
// assumes one clock; the bench asks for turn-on and faults through the request inputs
`timescale 1ns/1ps
module vmc_analog_model #(
  parameter int RAMP = 20
) (
  input  wire logic       clk_i,
  input  wire logic [7:0] on_req_i,
  input  wire logic [7:0] uv_req_i,
  input  wire logic [7:0] ov_req_i,
  output logic      [7:0] reg_on_o,
  output logic      [7:0] in_reg_o,
  output logic      [7:0] low_cmp_o,
  output logic      [7:0] high_cmp_o
);
  int ramp_cnt [8];

  initial
  begin
    reg_on_o = 8'h00;
    in_reg_o = 8'h00;
    foreach (ramp_cnt[i]) ramp_cnt[i] = 0;
  end

  // soft-start ramp: regulation is reported only after RAMP cycles of being on
  always @(posedge clk_i)
  begin
    for (int i = 0; i < 8; i++)
    begin
      reg_on_o[i] <= on_req_i[i];
      ramp_cnt[i] <= on_req_i[i] ? ((ramp_cnt[i] < RAMP) ? ramp_cnt[i] + 1 : RAMP) : 0;
      in_reg_o[i] <= on_req_i[i] && (ramp_cnt[i] == RAMP);
    end
  end

  // a ramping output sits below its low trip point, so the low comparator fires then
  assign low_cmp_o  = reg_on_o & (uv_req_i | ~in_reg_o);
  assign high_cmp_o = reg_on_o & ov_req_i;
endmodule // vmc_analog_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the voltage monitor control block
// assumes the analog model drives the regulator side and small low debounce and settling parameters
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
  import vmc_pkg::*;
  localparam int UVL [4] = '{4, 6, 8, 10};
  localparam int OVL [4] = '{int'(OV_DB0_CYC), int'(OV_DB1_CYC),
                             int'(OV_DB2_CYC), int'(OV_DB3_CYC)};
  logic clk_i = 0, rstn_i = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, irq, hit;
  logic [7:0] wb_adr = 8'h00, on_req = 8'h00, uv_req = 8'h00, ov_req = 8'h00;
  logic [3:0] wb_sel = 4'h3, sel_w = 4'h3;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, d;
  logic [7:0] reg_on, in_reg, low_cmp, high_cmp, active, lst, hst;
  logic [7:0][1:0] lc = '0, hc = '0;
  logic [NCH-1:0][PCT_W-1:0] lpct, hpct;
  int n_fail = 0, num_checks = 0, seed, ch;

  always #2.5 clk_i = ~clk_i;

  // high debounce keeps its real length; only the low filter and settling are shortened
  vmc_top #(.UV0_CYC(4), .UV1_CYC(6), .UV2_CYC(8), .UV3_CYC(10), .SETTLE_LIM(8)) u_vmc_top (
    .clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .buck_low_trip_code_i(lc[4:0]),
    .linear_low_trip_code_i(lc[7:5]), .buck_high_trip_code_i(hc[4:0]),
    .linear_high_trip_code_i(hc[7:5]), .reg_on_i(reg_on), .reg_in_regulation_i(in_reg),
    .low_cmp_i(low_cmp), .high_cmp_i(high_cmp), .low_trip_pct_o(lpct),
    .high_trip_pct_o(hpct), .monitor_active_o(active), .low_fault_status_o(lst),
    .high_fault_status_o(hst), .irq_o(irq));

  vmc_analog_model u_vmc_analog_model (.clk_i(clk_i), .on_req_i(on_req),
    .uv_req_i(uv_req), .ov_req_i(ov_req), .reg_on_o(reg_on), .in_reg_o(in_reg),
    .low_cmp_o(low_cmp), .high_cmp_o(high_cmp));

  function automatic logic [6:0] pct(input logic [1:0] c, input logic hi);
    return hi ? 7'h69 + 7'(2 * c) : 7'h5f - 7'(2 * c);
  endfunction

  task automatic wb_rw(input logic w, input logic [7:0] a, input logic [31:0] v,
                       output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= v;
    wb_sel <= sel_w;
    // only the watchdog ends a wait for acknowledge
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic watch(input int c, input int cnt, output logic h);
    h = 1'b0;
    repeat (cnt)
    begin
      @(posedge clk_i);
      h = h | lst[c];
    end
  endtask

  // raise one fault, time its status, then check event, irq and clearing
  task automatic deb_case(input int c, input logic hi, input int lim, input logic msk);
    int n;
    @(posedge clk_i);
    if (hi) ov_req[c] <= 1'b1;
    else uv_req[c] <= 1'b1;
    for (n = 0; n < lim + 10; n++)
    begin
      @(posedge clk_i);
      if ((hi ? hst[c] : lst[c]) === 1'b1) break;
    end
    `CHK(n >= lim && n <= lim + 4, 1'b1)
    `CHK(irq, msk)
    ov_req[c] <= 1'b0;
    uv_req[c] <= 1'b0;
    repeat (5) @(posedge clk_i);
    `CHK((hi ? hst[c] : lst[c]), 1'b0)
    wb_rw(1'b0, OFS_IRQ_STAT, 32'h0, d);
    `CHK(d[hi * 8 + c], 1'b1)
    wb_rw(1'b1, OFS_IRQ_STAT, 32'h1 << (hi * 8 + c), d);
    @(posedge clk_i);
    `CHK(irq, 1'b0)
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #(5 * 90000);
    n_fail++;
    end_sim();
  end

  initial
  begin
    seed = 32'h3536;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    wb_rw(1'b0, OFS_CTRL, 32'h0, d);
    `CHK(d[4:0], 5'h02)
    // a write without the low byte lane must leave the control fields alone
    sel_w = 4'h2;
    wb_rw(1'b1, OFS_CTRL, 32'h1f, d);
    sel_w = 4'h3;
    wb_rw(1'b0, OFS_CTRL, 32'h0, d);
    `CHK(d[4:0], 5'h02)
    wb_rw(1'b0, OFS_MON_EN, 32'h0, d);
    `CHK(d[7:0], 8'hff)
    wb_rw(1'b1, 8'h3c, 32'hffff_ffff, d);
    wb_rw(1'b0, 8'h3c, 32'h0, d);
    `CHK(d, 32'h0)
    on_req <= 8'hff;
    repeat (40) @(posedge clk_i);
    `CHK(active, 8'hff)
    for (int r = 0; r < 8; r++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        lc[i] <= (r < 4) ? 2'(r) : 2'($random(seed));
        hc[i] <= (r < 4) ? 2'(3 - r) : 2'($random(seed));
      end
      repeat (5) @(posedge clk_i);
      for (int i = 0; i < 8; i++)
      begin
        `CHK(lpct[i], pct(lc[i], 1'b0))
        `CHK(hpct[i], pct(hc[i], 1'b1))
      end
    end
    deb_case(0, 1'b0, UVL[2], 1'b0);
    deb_case(0, 1'b1, OVL[0], 1'b0);
    wb_rw(1'b1, OFS_IRQ_MASK, 32'hffff, d);
    for (int s = 0; s < 4; s++)
    begin
      wb_rw(1'b1, OFS_CTRL, 32'(s * 5), d);
      deb_case($unsigned($random(seed)) % 8, 1'b0, UVL[s], 1'b1);
      deb_case($unsigned($random(seed)) % 8, 1'b1, OVL[s], 1'b1);
    end
    // glitches shorter than the filter must never add up across a dropout
    ch = $unsigned($random(seed)) % 8;
    uv_req[ch] <= 1'b1;
    repeat (7) @(posedge clk_i);
    uv_req[ch] <= 1'b0;
    repeat (2) @(posedge clk_i);
    uv_req[ch] <= 1'b1;
    watch(ch, 7, hit);
    uv_req[ch] <= 1'b0;
    watch(ch, 6, d[0]);
    `CHK(hit | d[0], 1'b0)
    wb_rw(1'b1, OFS_CTRL, 32'h0, d);
    on_req[2] <= 1'b0;
    repeat (4) @(posedge clk_i);
    on_req[2] <= 1'b1;
    watch(2, 30, hit);
    `CHK(hit, 1'b0)
    uv_req[3] <= 1'b1;
    repeat (12) @(posedge clk_i);
    `CHK(lst[3], 1'b1)
    wb_rw(1'b0, OFS_STATUS, 32'h0, d);
    `CHK(d[15:0], 16'h0008)
    wb_rw(1'b1, OFS_CTRL, 32'h10, d);
    wb_rw(1'b1, OFS_MON_EN, 32'hf7, d);
    wb_rw(1'b0, OFS_MON_EN, 32'h0, d);
    `CHK(d[7:0], 8'hff)
    wb_rw(1'b1, OFS_KEY, 32'h5a, d);
    wb_rw(1'b1, OFS_MON_EN, 32'hf7, d);
    wb_rw(1'b0, OFS_MON_EN, 32'h0, d);
    `CHK(d[7:0], 8'hff)
    wb_rw(1'b1, OFS_KEY, 32'(UNLOCK_KEY), d);
    wb_rw(1'b1, OFS_MON_EN, 32'hf7, d);
    wb_rw(1'b0, OFS_MON_EN, 32'h0, d);
    `CHK(d[7:0], 8'hf7)
    `CHK(lst[3], 1'b0)
    `CHK(active[3], 1'b0)
    wb_rw(1'b1, OFS_KEY, 32'(UNLOCK_KEY), d);
    wb_rw(1'b1, OFS_MON_EN, 32'hff, d);
    watch(3, 8, hit);
    `CHK(hit, 1'b0)
    repeat (20) @(posedge clk_i);
    `CHK(lst[3], 1'b1)
    uv_req[3] <= 1'b0;
    repeat (5) @(posedge clk_i);
    end_sim();
  end
endmodule // tb_top
